// *** rtl/acs_pkg.sv ***
package acs_pkg;
   // Command bytes
   localparam logic [7:0] CMD_RESET          = 8'h06;
   localparam logic [7:0] REGISTER_WRITE_CMD = 8'h43;
   localparam logic [7:0] REGISTER_READ_CMD  = 8'h23;
   localparam logic [7:0] CMD_START          = 8'h08;
   localparam logic [7:0] SLEEP_CMD          = 8'h02;
   localparam logic [7:0] NOP_BYTE           = 8'h00;

   // Configuration layout, byte 0 sent first
   localparam int         CFG_BYTES      = 4;
   localparam int         RESULT_BITS    = 24;
   localparam int         MUX_POS        = 4;
   localparam int         GAIN_POS       = 1;
   localparam int         BYPASS_POS     = 0;
   localparam int         CONT_POS       = 2;
   localparam int         VREF_POS       = 6;
   localparam int         RDYSEL_POS     = 1;
   localparam logic [3:0] MUX_SHORT      = 4'hE;
   localparam logic [7:0] CFG_BYTE_RESET = 8'h00;
   localparam logic [23:0] INT_REF_UV    = 24'h1F4000;

   // Timing
   localparam int CLK_NS            = 25;
   localparam int PWRUP_US          = 50;
   localparam int DEV_CLK_NS        = 250;
   localparam int RESET_EXTRA_CLKS  = 32;
   localparam int PWRUP_CYCLES      = (PWRUP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int RESET_WAIT_CYCLES =
      (PWRUP_US * 1000 + RESET_EXTRA_CLKS * DEV_CLK_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCLK_HALF_CYCLES  = 8;

   // Host register map (APB byte addresses)
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_STATUS     = 8'h04;
   localparam logic [7:0] REG_CONFIG     = 8'h08;
   localparam logic [7:0] REG_READBACK   = 8'h0C;
   localparam logic [7:0] REG_DATA       = 8'h10;
   localparam logic [7:0] REG_OFFSET     = 8'h14;
   localparam logic [7:0] REG_INT_STATUS = 8'h18;
   localparam logic [7:0] REG_INT_CLEAR  = 8'h1C;
   localparam logic [7:0] REG_INT_ENABLE = 8'h20;
   localparam int         AUTO_POS       = 8;
   localparam int         INT_DONE       = 0;
   localparam int         INT_DATA       = 1;

   typedef enum logic [2:0] {
      OP_NONE  = 3'h0,
      OP_RESET = 3'h1,
      OP_WRITE = 3'h2,
      OP_READ  = 3'h3,
      OP_START = 3'h4,
      OP_SLEEP = 3'h5,
      OP_DATA  = 3'h6
   } acs_op_type;
endpackage

// *** rtl/acs_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface acs_link_if;
   logic cs_n;
   logic sclk;
   logic din;
   logic dout;
   logic conversion_ready_n;

   modport dev_mp (input cs_n, input sclk, input din, output dout, output conversion_ready_n);
   modport host_mp (output cs_n, output sclk, output din, input dout, input conversion_ready_n);
endinterface
`default_nettype wire

// *** rtl/acs_sync_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_sync_edge #(
   parameter bit INIT = 1'b0
) (
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic d,
   output logic      q,
   output logic      rise,
   output logic      fall
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
         prev_reg <= INIT;
      end else begin
         meta_reg <= d;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign q    = sync_reg;
   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;
endmodule
`default_nettype wire

// *** rtl/acs_device.sv ***
// Function
// - Host waits 50 us after power-up.
// - Link runs SPI mode 1 both sides.
// - Command 06h reinitializes; host waits afterwards.
// - Command 43h writes four configuration bytes.
// - Command 23h returns all configuration bytes.
// - Command 08h starts conversions, continuous if set.
// - Chip select high resets serial state.
// - Ready pin falls on new result.
// - Twenty-four clocks shift out the result.
// - Command 02h stops conversion, enters sleep.
// - Input select 1110 shorts inputs together.
// - Amplifier bypass limits gain to four.
// - Full scale is reference over gain.
// - Change on rising, sample on falling.
// - Ready select bit mirrors ready onto data.
`timescale 1ns/1ps
`default_nettype none
module acs_device #(
   parameter int                 CONV_CYCLES = 2000,
   parameter logic signed [23:0] OFFSET_CODE = 24'sh000010
) (
   input  wire logic               mclk,
   input  wire logic               reset_n,
   acs_link_if.dev_mp              link,
   input  wire logic signed [23:0] analog_uv,
   input  wire logic        [23:0] ext_ref_uv,
   output logic                    converting,
   output logic                    sleeping,
   output logic                    inputs_shorted
);
   import acs_pkg::*;

   if (CONV_CYCLES < 2) begin : g_chk
      $error("CONV_CYCLES must be at least 2");
   end

   typedef enum logic [2:0] {
      PH_CMD    = 3'b001,
      PH_WDATA  = 3'b010,
      PH_IGNORE = 3'b100
   } acs_phase_type;

   function automatic logic [7:0] eff_gain(input logic [2:0] g, input logic bypass);
      if (bypass && g > 3'h2) begin
         return 8'h04;
      end
      return 8'(1 << g);
   endfunction

   function automatic logic [23:0] scale_code(input logic signed [23:0] vin,
                                              input logic [7:0] gain,
                                              input logic [23:0] vref);
      logic signed [63:0] num;
      logic signed [63:0] quo;
      num = 64'(vin) * $signed({56'h0, gain});
      num = num <<< 23;
      quo = (vref == 24'h0) ? 64'sh0 : num / $signed({40'h0, vref});
      if (quo > 64'sh7FFFFF) begin
         return 24'h7FFFFF;
      end
      if (quo < -64'sh800000) begin
         return 24'h800000;
      end
      return quo[23:0];
   endfunction

   logic cs_q, cs_fall, sclk_rise, sclk_fall, din_q;

   acs_sync_edge #(.INIT(1'b1)) u_cs (
      .mclk(mclk), .reset_n(reset_n), .d(link.cs_n),
      .q(cs_q), .rise(), .fall(cs_fall)
   );
   acs_sync_edge #(.INIT(1'b0)) u_sclk (
      .mclk(mclk), .reset_n(reset_n), .d(link.sclk),
      .q(), .rise(sclk_rise), .fall(sclk_fall)
   );
   acs_sync_edge #(.INIT(1'b0)) u_din (
      .mclk(mclk), .reset_n(reset_n), .d(link.din),
      .q(din_q), .rise(), .fall()
   );

   logic          [7:0]  cfg_reg [CFG_BYTES];
   acs_phase_type        phase_reg;
   logic          [2:0]  bit_cnt_reg;
   logic          [6:0]  rx_reg;
   logic          [1:0]  wr_idx_reg;
   logic          [31:0] tx_reg;
   logic                 started_reg;
   logic                 dout_reg;
   logic                 running_reg;
   logic                 sleeping_reg;
   logic                 ready_n_reg;
   logic          [23:0] result_reg;
   logic          [31:0] conv_cnt_reg;

   // Byte assembly: falling sclk samples din
   wire        active     = ~cs_q;
   wire        bit_fall   = sclk_fall & active;
   wire        bit_rise   = sclk_rise & active;
   wire        byte_done  = bit_fall & (bit_cnt_reg == 3'h7);
   wire [7:0]  new_byte   = {rx_reg, din_q};
   wire        cmd_take   = byte_done & (phase_reg == PH_CMD);
   wire        do_reset   = cmd_take & (new_byte == CMD_RESET);
   wire        do_write   = cmd_take & (new_byte == REGISTER_WRITE_CMD);
   wire        do_read    = cmd_take & (new_byte == REGISTER_READ_CMD);
   wire        do_start   = cmd_take & (new_byte == CMD_START);
   wire        do_sleep   = cmd_take & (new_byte == SLEEP_CMD);
   wire        wr_take    = byte_done & (phase_reg == PH_WDATA);
   wire        rd_start   = bit_rise & ~started_reg;

   // Configuration fields
   wire [3:0]  mux_sel    = cfg_reg[0][MUX_POS +: 4];
   wire [2:0]  gain_sel   = cfg_reg[0][GAIN_POS +: 3];
   wire        bypass     = cfg_reg[0][BYPASS_POS];
   wire        cont_mode  = cfg_reg[1][CONT_POS];
   wire [1:0]  vref_sel   = cfg_reg[2][VREF_POS +: 2];
   wire        rdy_sel    = cfg_reg[3][RDYSEL_POS];
   wire [7:0]  gain       = eff_gain(gain_sel, bypass);
   wire        shorted    = (mux_sel == MUX_SHORT);
   wire signed [23:0] vin = shorted ? 24'sh000000 : analog_uv;
   wire [23:0] vref       = (vref_sel == 2'h0) ? INT_REF_UV : ext_ref_uv;
   wire [23:0] conv_code  = scale_code(vin, gain, vref) + OFFSET_CODE;
   wire        conv_end   = running_reg & (conv_cnt_reg == 32'(CONV_CYCLES - 1));
   wire [31:0] cfg_word   = {cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3]};

   // Serial shifter
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         phase_reg   <= PH_CMD;
         bit_cnt_reg <= 3'h0;
         rx_reg      <= 7'h0;
         wr_idx_reg  <= 2'h0;
      end else if (cs_q) begin
         phase_reg   <= PH_CMD;
         bit_cnt_reg <= 3'h0;
         wr_idx_reg  <= 2'h0;
      end else if (bit_fall) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         rx_reg      <= new_byte[6:0];
         if (do_write) begin
            phase_reg <= PH_WDATA;
         end else if (cmd_take && !do_reset) begin
            phase_reg <= PH_IGNORE;
         end else if (wr_take) begin
            wr_idx_reg <= wr_idx_reg + 2'h1;
            if (wr_idx_reg == 2'(CFG_BYTES - 1)) begin
               phase_reg <= PH_IGNORE;
            end
         end
      end
   end

   // Output shifter: rising sclk launches the next bit
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_reg      <= 32'h0;
         started_reg <= 1'b0;
         dout_reg    <= 1'b1;
      end else if (cs_q) begin
         started_reg <= 1'b0;
         dout_reg    <= 1'b1;
      end else if (cs_fall) begin
         tx_reg <= {result_reg, 8'h00};
      end else if (do_read) begin
         tx_reg <= cfg_word;
      end else if (bit_rise) begin
         dout_reg    <= tx_reg[31];
         tx_reg      <= {tx_reg[30:0], 1'b0};
         started_reg <= 1'b1;
      end else if (!started_reg) begin
         dout_reg <= rdy_sel ? ready_n_reg : 1'b1;
      end
   end

   // Configuration storage
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            cfg_reg[i] <= CFG_BYTE_RESET;
         end
      end else if (do_reset) begin
         for (int i = 0; i < CFG_BYTES; i++) begin
            cfg_reg[i] <= CFG_BYTE_RESET;
         end
      end else if (wr_take) begin
         cfg_reg[wr_idx_reg] <= new_byte;
      end
   end

   // Conversion engine
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         running_reg  <= 1'b0;
         sleeping_reg <= 1'b0;
         ready_n_reg  <= 1'b1;
         result_reg   <= 24'h0;
         conv_cnt_reg <= 32'h0;
      end else if (do_reset) begin
         running_reg  <= 1'b0;
         sleeping_reg <= 1'b0;
         ready_n_reg  <= 1'b1;
         result_reg   <= 24'h0;
         conv_cnt_reg <= 32'h0;
      end else if (do_sleep) begin
         running_reg  <= 1'b0;
         sleeping_reg <= 1'b1;
         conv_cnt_reg <= 32'h0;
      end else if (do_start) begin
         running_reg  <= 1'b1;
         sleeping_reg <= 1'b0;
         conv_cnt_reg <= 32'h0;
      end else if (conv_end) begin
         result_reg   <= conv_code;
         ready_n_reg  <= 1'b0;
         conv_cnt_reg <= 32'h0;
         running_reg  <= cont_mode;
      end else begin
         if (running_reg) begin
            conv_cnt_reg <= conv_cnt_reg + 32'h1;
         end
         if (rd_start) begin
            ready_n_reg <= 1'b1;
         end
      end
   end

   assign link.dout               = dout_reg;
   assign link.conversion_ready_n = ready_n_reg;
   assign converting              = running_reg;
   assign sleeping                = sleeping_reg;
   assign inputs_shorted          = shorted;
endmodule
`default_nettype wire

// *** rtl/acs_host.sv ***
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module acs_host #(
   parameter int HALF_CYCLES = acs_pkg::SCLK_HALF_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   acs_link_if.host_mp      link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq
);
   import acs_pkg::*;

   if (HALF_CYCLES < 6) begin : g_chk
      $error("HALF_CYCLES must be at least 6 for the synchronisers");
   end

   typedef enum logic [6:0] {
      H_PWRUP = 7'b0000001,
      H_IDLE  = 7'b0000010,
      H_SETUP = 7'b0000100,
      H_HIGH  = 7'b0001000,
      H_LOW   = 7'b0010000,
      H_HOLD  = 7'b0100000,
      H_WAIT  = 7'b1000000
   } acs_hstate_type;

   logic dout_q, ready_fall;

   acs_sync_edge #(.INIT(1'b1)) u_dout (
      .mclk(mclk), .reset_n(reset_n), .d(link.dout),
      .q(dout_q), .rise(), .fall()
   );
   acs_sync_edge #(.INIT(1'b1)) u_rdy (
      .mclk(mclk), .reset_n(reset_n), .d(link.conversion_ready_n),
      .q(), .rise(), .fall(ready_fall)
   );

   acs_hstate_type state_reg;
   acs_op_type     op_reg, cur_op_reg;
   logic [11:0]    cnt_reg;
   logic [39:0]    tx_reg;
   logic [5:0]     bits_reg;
   logic [31:0]    rx_reg, config_reg, readback_reg;
   logic [23:0]    data_reg, offset_reg;
   logic [1:0]     int_status_reg, int_enable_reg;
   logic           auto_reg, pend_reg, cs_n_reg, sclk_reg, din_reg, irq_reg;
   logic [31:0]    prdata_reg;

   function automatic logic [5:0] op_bits(input acs_op_type op);
      case (op)
         OP_WRITE, OP_READ: op_bits = 6'h28;
         OP_DATA:           op_bits = 6'h18;
         default:           op_bits = 6'h08;
      endcase
   endfunction

   function automatic logic [7:0] op_cmd(input acs_op_type op);
      case (op)
         OP_RESET: op_cmd = CMD_RESET;
         OP_WRITE: op_cmd = REGISTER_WRITE_CMD;
         OP_READ:  op_cmd = REGISTER_READ_CMD;
         OP_START: op_cmd = CMD_START;
         OP_SLEEP: op_cmd = SLEEP_CMD;
         default:  op_cmd = NOP_BYTE;
      endcase
   endfunction

   wire        apb_wr    = psel & penable & pwrite;
   wire        apb_setup = psel & ~penable;
   wire        idle      = (state_reg == H_IDLE);
   wire        go_ok     = idle & (cnt_reg == 12'h0);
   wire        take_op   = go_ok & (op_reg != OP_NONE);
   wire        take_rd   = go_ok & (op_reg == OP_NONE) & pend_reg & auto_reg;
   wire        next_op_w = apb_wr & (paddr == REG_CTRL);
   wire        done      = (state_reg == H_HOLD) & (cnt_reg == 12'h0);
   wire        done_data = done & (cur_op_reg == OP_DATA);
   wire        cnt_zero  = (cnt_reg == 12'h0);
   wire [11:0] half      = 12'(HALF_CYCLES - 1);
   wire acs_op_type sel_op = take_op ? op_reg : OP_DATA;
   wire [39:0] load_tx   = (sel_op == OP_WRITE) ? {op_cmd(sel_op), config_reg}
                                                : {op_cmd(sel_op), 32'h0};
   wire [23:0] corrected = rx_reg[23:0] - offset_reg;
   wire        hit       = (paddr <= REG_INT_ENABLE) & (paddr[1:0] == 2'h0);
   wire [1:0]  int_set   = {done_data, done};
   wire [1:0]  int_clr   = (apb_wr && paddr == REG_INT_CLEAR) ? pwdata[1:0] : 2'h0;

   // Link sequencer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg  <= H_PWRUP;
         cnt_reg    <= 12'(PWRUP_CYCLES - 1);
         cur_op_reg <= OP_NONE;
         tx_reg     <= 40'h0;
         bits_reg   <= 6'h0;
         rx_reg     <= 32'h0;
         cs_n_reg   <= 1'b1;
         sclk_reg   <= 1'b0;
         din_reg    <= 1'b0;
      end else begin
         if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 12'h1;
         end
         case (state_reg)
            H_PWRUP: if (cnt_zero) state_reg <= H_IDLE;
            H_IDLE: begin
               if (take_op || take_rd) begin
                  cur_op_reg <= sel_op;
                  tx_reg     <= load_tx;
                  bits_reg   <= op_bits(sel_op);
                  cs_n_reg   <= 1'b0;
                  cnt_reg    <= half;
                  state_reg  <= H_SETUP;
               end
            end
            H_SETUP, H_LOW: begin
               if (cnt_zero) begin
                  cnt_reg <= half;
                  if (bits_reg == 6'h0) begin
                     state_reg <= H_HOLD;
                  end else begin
                     sclk_reg  <= 1'b1;
                     din_reg   <= tx_reg[39];
                     tx_reg    <= {tx_reg[38:0], 1'b0};
                     state_reg <= H_HIGH;
                  end
               end
            end
            H_HIGH: begin
               if (cnt_zero) begin
                  sclk_reg  <= 1'b0;
                  rx_reg    <= {rx_reg[30:0], dout_q};
                  bits_reg  <= bits_reg - 6'h1;
                  cnt_reg   <= half;
                  state_reg <= H_LOW;
               end
            end
            H_HOLD: begin
               if (cnt_zero) begin
                  cs_n_reg <= 1'b1;
                  if (cur_op_reg == OP_RESET) begin
                     cnt_reg   <= 12'(RESET_WAIT_CYCLES - 1);
                     state_reg <= H_WAIT;
                  end else begin
                     cnt_reg   <= half;
                     state_reg <= H_IDLE;
                  end
               end
            end
            H_WAIT: if (cnt_zero) state_reg <= H_IDLE;
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   // Software registers and events
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         op_reg         <= OP_NONE;
         auto_reg       <= 1'b0;
         pend_reg       <= 1'b0;
         config_reg     <= 32'h0;
         readback_reg   <= 32'h0;
         data_reg       <= 24'h0;
         offset_reg     <= 24'h0;
         int_status_reg <= 2'h0;
         int_enable_reg <= 2'h0;
         irq_reg        <= 1'b0;
      end else begin
         if (take_op) begin
            op_reg <= OP_NONE;
         end else if (next_op_w && op_reg == OP_NONE && pwdata[2:0] <= 3'h5) begin
            op_reg <= acs_op_type'(pwdata[2:0]);
         end
         if (next_op_w) auto_reg <= pwdata[AUTO_POS];
         if (apb_wr && paddr == REG_CONFIG) config_reg <= pwdata;
         if (apb_wr && paddr == REG_OFFSET) offset_reg <= pwdata[23:0];
         if (apb_wr && paddr == REG_INT_ENABLE) int_enable_reg <= pwdata[1:0];
         pend_reg <= ready_fall | (pend_reg & ~take_rd);
         if (done && cur_op_reg == OP_READ) readback_reg <= rx_reg;
         if (done_data) data_reg <= corrected;
         int_status_reg <= int_set | (int_status_reg & ~int_clr);
         irq_reg        <= |(int_status_reg & int_enable_reg);
      end
   end

   // APB read data captured in the setup cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         prdata_reg <= 32'h0;
      end else if (apb_setup && !pwrite) begin
         case (paddr)
            REG_CTRL:       prdata_reg <= {23'h0, auto_reg, 5'h0, op_reg};
            REG_STATUS:     prdata_reg <= {29'h0, auto_reg, ~state_reg[0],
                                           ~idle | (op_reg != OP_NONE)};
            REG_CONFIG:     prdata_reg <= config_reg;
            REG_READBACK:   prdata_reg <= readback_reg;
            REG_DATA:       prdata_reg <= {{8{data_reg[23]}}, data_reg};
            REG_OFFSET:     prdata_reg <= {8'h0, offset_reg};
            REG_INT_STATUS: prdata_reg <= {30'h0, int_status_reg};
            REG_INT_ENABLE: prdata_reg <= {30'h0, int_enable_reg};
            default:        prdata_reg <= 32'h0;
         endcase
      end
   end

   assign prdata    = prdata_reg;
   assign pready    = 1'b1;
   assign pslverr   = psel & penable & ~hit;
   assign irq       = irq_reg;
   assign link.cs_n = cs_n_reg;
   assign link.sclk = sclk_reg;
   assign link.din  = din_reg;
endmodule
`default_nettype wire

// *** verification/acs_link_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module acs_link_monitor (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic conversion_ready_n
);
   import acs_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   logic [11:0] up_reg;
   logic [5:0]  bits_reg;
   always_ff @(posedge mclk or negedge reset_n)
      if (!reset_n) up_reg <= '0;
      else if (up_reg < 12'(PWRUP_CYCLES)) up_reg <= up_reg + 12'h001;
   always_ff @(posedge mclk or negedge reset_n)
      if (!reset_n) bits_reg <= '0;
      else if (cs_n) bits_reg <= '0;
      else if ($rose(sclk)) bits_reg <= bits_reg + 6'h01;
   AST_PWRUP: assert property (!cs_n |-> up_reg >= 12'(PWRUP_CYCLES - 1))
      else $error("frame before power-up wait");
   AST_IDLE: assert property (cs_n |-> !sclk)
      else $error("sclk high outside frame");
   AST_LEAD: assert property ($fell(cs_n) |-> !sclk [*8])
      else $error("sclk too soon after select");
   AST_HIGH: assert property ($rose(sclk) |-> sclk [*8])
      else $error("sclk high phase short");
   AST_DIN: assert property (!cs_n && $changed(din) |-> $rose(sclk))
      else $error("din moved off rising edge");
   AST_DOUT: assert property ($fell(sclk) |-> $stable(dout))
      else $error("dout moved at sample edge");
   AST_FRAME: assert property ($rose(cs_n) |-> bits_reg inside {6'h08, 6'h18, 6'h28})
      else $error("frame length wrong");
   AST_READY: assert property ($rose(conversion_ready_n) |-> !cs_n)
      else $error("ready cleared outside frame");
   cover property ($rose(cs_n) && bits_reg == 6'h28);
   cover property ($rose(cs_n) && bits_reg == 6'h18);
   cover property ($fell(conversion_ready_n));
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; \
   if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
   import acs_pkg::*;
   logic               mclk = 0;
   logic               reset_n = 0;
   logic               psel = 0;
   logic               penable = 0;
   logic               pwrite = 0;
   logic [7:0]         paddr = '0;
   logic [31:0]        pwdata = '0;
   logic [31:0]        prdata, rd;
   logic               pready, pslverr, irq, err, conv, slp, shrt;
   logic signed [23:0] ain = '0;
   logic [1:0]         en = '0;
   int                 n_fail = 0;
   int                 checked = 0;
   logic [32:0]        rows [3] = '{33'h1E0000000, 33'h00A041002, 33'h007040000};
   initial forever #12.5 mclk = ~mclk;
   acs_link_if link ();
   acs_host acs_host_i (.mclk, .reset_n, .link(link.host_mp), .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
   acs_device #(.CONV_CYCLES(50)) acs_device_i (.mclk, .reset_n, .link(link.dev_mp),
      .analog_uv(ain), .ext_ref_uv(24'h2DC6C0), .converting(conv), .sleeping(slp),
      .inputs_shorted(shrt));
   acs_link_monitor acs_link_monitor_i (.mclk, .reset_n, .cs_n(link.cs_n), .sclk(link.sclk),
      .din(link.din), .dout(link.dout), .conversion_ready_n(link.conversion_ready_n));
   task close_out(input bit hang);
      if (hang) n_fail++;
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      for (int i = 0; i < 9 && pready !== 1'b1; i++) @(posedge mclk);
      if (pready !== 1'b1) close_out(1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wait_int(input int b);
      rd = '0;
      for (int i = 0; i < 3000 && rd[b] !== 1'b1; i++) apb(0, REG_INT_STATUS, 0);
      if (rd[b] !== 1'b1) close_out(1);
      `CHK("irq", |(rd[1:0] & en), irq)
      apb(1, REG_INT_CLEAR, 32'h3);
   endtask
   task get_data(input logic [31:0] e);
      wait_int(INT_DATA);
      wait_int(INT_DATA);
      apb(0, REG_DATA, 0);
      `CHK("data", e, rd)
   endtask
   task cmd(input logic [31:0] c);
      apb(1, REG_CTRL, c);
      rd = 32'h1;
      for (int i = 0; i < 3000 && rd[0] !== 1'b0; i++) apb(0, REG_STATUS, 0);
      if (rd[0] !== 1'b0) close_out(1);
      wait_int(INT_DONE);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      reset_n <= 1;
      @(posedge mclk);
      `CHK("cs", 1'b1, link.cs_n)
      en = 2'b01;
      apb(1, REG_INT_ENABLE, {30'h0, en});
      for (int r = 0; r < 3; r++) begin
         apb(1, REG_CONFIG, rows[r][31:0]);
         cmd(32'h2);
         cmd(32'h3);
         apb(0, REG_READBACK, 0);
         `CHK("readback", rows[r][31:0], rd)
         `CHK("shorted", rows[r][32], shrt)
      end
      apb(1, REG_OFFSET, 32'h10);
      en = 2'b11;
      apb(1, REG_INT_ENABLE, {30'h0, en});
      ain <= 24'sd256000;
      apb(1, REG_CTRL, 32'h104);
      get_data(32'h00400000);
      `CHK("conv", 1'b1, conv)
      ain <= -24'sd256000;
      get_data(32'hFFC00000);
      en = 2'b01;
      apb(1, REG_INT_ENABLE, {30'h0, en});
      cmd(32'h5);
      `CHK("sleep", 2'b10, {slp, conv})
      cmd(32'h1);
      cmd(32'h3);
      apb(0, REG_READBACK, 0);
      `CHK("reinit", 32'h0, rd)
      apb(0, 8'h24, 0);
      `CHK("unmapped", 33'h100000000, {err, rd})
      close_out(0);
   end
endmodule
`default_nettype wire
